// File: hw/delay_channel.sv
// One delay channel: code-driven delay line with output block
`timescale 1ns/1ps
module delay_channel
	import delay_ctrl_pkg::*;
#(
	parameter int DEPTH = 1024
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Settings
	input  wire delay_code_t code_i,
	input  wire logic        block_i,
	// Synchronised channel input
	input  wire logic        in_i,
	// Delayed true and complement outputs
	output logic             out_o,
	output logic             out_comp_o
);
	import delay_ctrl_pkg::*;

	logic [DEPTH-1:0] line;
	logic             tap;
	logic [DEPTH-1:0] blk_line;
	logic             blk_tap;

	// Shift line for data and block level, one step a cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line     <= '0;
			blk_line <= '0;
		end else begin
			line     <= {line[DEPTH-2:0], in_i};
			blk_line <= {blk_line[DEPTH-2:0], block_i};
		end
	end

	// Linear tap: one cycle more delay per code step, larger code, longer delay
	assign tap     = line[code_i];
	assign blk_tap = blk_line[code_i];

	// Output pair, forced low/high when blocked after delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_o      <= 1'b0;
			out_comp_o <= 1'b1;
		end else if (blk_tap) begin
			out_o      <= 1'b0;
			out_comp_o <= 1'b1;
		end else begin
			out_o      <= tap;
			out_comp_o <= ~tap;
		end
	end
endmodule : delay_channel

// File: hw/dual_delay_serial_control.sv
// Top of the dual delay serial control block
// What this block does
// - 20-bit word: ten bits per channel code
// - Shift data in on serial clock rise
// - Latches transparent while load strobe high
// - Load strobe rise transfers codes to channels
// - Chain end drives serial data out
// - Block high forces output low, complement high
// - Block low: input reproduced after delay
// - Outputs follow inputs without inversion
// - Unconnected serial and block inputs read low (this logic adds no pull-down; the pins are only synchronised)
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "delay_ctrl_map.svh"
module dual_delay_serial_control
	import delay_ctrl_pkg::*;
#(
	parameter int DEPTH = 1024
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Serial programming pins
	input  wire logic        serial_data_in_i,
	input  wire logic        serial_clock_i,
	input  wire logic        load_strobe_i,
	output logic             serial_data_out_o,
	// Output block pins
	input  wire logic        channel_a_output_block_i,
	input  wire logic        channel_b_output_block_i,
	// Channel data
	input  wire logic        channel_a_input_i,
	input  wire logic        channel_b_input_i,
	output logic             channel_a_output_o,
	output logic             channel_a_output_comp_o,
	output logic             channel_b_output_o,
	output logic             channel_b_output_comp_o
);
	import delay_ctrl_pkg::*;

	logic        sdi;
	logic        sclk;
	logic        load_strobe;
	logic        blk_a_pin;
	logic        blk_b_pin;
	logic        in_a;
	logic        in_b;
	logic        sclk_d;
	logic        load_strobe_d;
	logic        sclk_rise;
	logic        load_strobe_rise;
	ctrl_word_t  chain;
	ctrl_word_t  latch;
	delay_code_t channel_a_delay_code;
	delay_code_t channel_b_delay_code;
	logic [1:0]  ctrl;
	load_state_t load_state;
	logic        loads_seen;
	logic [4:0]  bit_count;
	logic        blk_a;
	logic        blk_b;
	logic        a_out;
	logic        a_comp;
	logic        b_out;
	logic        b_comp;

	// Pin synchronisers; no pull-down is added here, a floating pin is only synchronised
	pin_sync u_sync_sdi (.clk_i(clk_i), .rst_i(rst_i), .pin_i(serial_data_in_i), .level_o(sdi));
	pin_sync u_sync_sclk (.clk_i(clk_i), .rst_i(rst_i), .pin_i(serial_clock_i), .level_o(sclk));
	pin_sync u_sync_load (.clk_i(clk_i), .rst_i(rst_i), .pin_i(load_strobe_i), .level_o(load_strobe));
	pin_sync u_sync_ba (.clk_i(clk_i), .rst_i(rst_i),
		.pin_i(channel_a_output_block_i), .level_o(blk_a_pin));
	pin_sync u_sync_bb (.clk_i(clk_i), .rst_i(rst_i),
		.pin_i(channel_b_output_block_i), .level_o(blk_b_pin));
	pin_sync u_sync_ina (.clk_i(clk_i), .rst_i(rst_i), .pin_i(channel_a_input_i), .level_o(in_a));
	pin_sync u_sync_inb (.clk_i(clk_i), .rst_i(rst_i), .pin_i(channel_b_input_i), .level_o(in_b));

	// Edge detect on synchronised strobes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d  <= 1'b0;
			load_strobe_d <= 1'b0;
		end else begin
			sclk_d  <= sclk;
			load_strobe_d <= load_strobe;
		end
	end
	assign sclk_rise  = sclk & ~sclk_d;
	assign load_strobe_rise = load_strobe & ~load_strobe_d;

	// Shift chain: new bit in at LSB, MSB leaves toward cascade
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chain <= '0;
		end else if (sclk_rise) begin
			chain <= {chain[`WORD_WIDTH-2:0], sdi};
		end
	end

	// Count of bits since last load, for status only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_count <= 5'h00;
		end else if (load_strobe_rise) begin
			bit_count <= 5'h00;
		end else if (sclk_rise && bit_count != 5'h1f) begin
			bit_count <= bit_count + 5'h01;
		end
	end

	// Cascade output from the far end of the chain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_data_out_o <= 1'b0;
		end else begin
			serial_data_out_o <= chain[`WORD_WIDTH-1];
		end
	end

	// Transparent latch while strobe high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch <= {`CODE_RESET, `CODE_RESET};
		end else if (load_strobe) begin
			latch <= chain;
		end
	end

	// Load state tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_state <= LOAD_IDLE;
		end else begin
			case (load_state)
				LOAD_IDLE: if (load_strobe_rise) load_state <= LOAD_OPEN;
				LOAD_OPEN: load_state <= load_strobe ? LOAD_HOLD : LOAD_IDLE;
				LOAD_HOLD: if (!load_strobe) load_state <= LOAD_IDLE;
				default:   load_state <= LOAD_IDLE;
			endcase
		end
	end

	// Delay codes read straight from the latch, so they follow it while open
	assign channel_a_delay_code = latch[`CODE_A_LSB +: `CODE_WIDTH];
	assign channel_b_delay_code = latch[`CODE_B_LSB +: `CODE_WIDTH];

	// Sticky flag: a load has happened since reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loads_seen <= 1'b0;
		end else if (load_strobe_rise) begin
			loads_seen <= 1'b1;
		end
	end

	// Software block bits in control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `CTRL_RESET;
		end else if (cyc_i && stb_i && we_i && ack_o
			&& adr_i == {1'b0, `REG_CTRL} && sel_i[0]) begin
			// Write lands at the edge where the master sees ack
			ctrl <= dat_i[1:0];
		end
	end

	// Block is pin or software bit
	assign blk_a = blk_a_pin | ctrl[`CTRL_BLOCK_A];
	assign blk_b = blk_b_pin | ctrl[`CTRL_BLOCK_B];

	// The two channels
	delay_channel #(.DEPTH(DEPTH)) u_chan_a (
		.clk_i(clk_i), .rst_i(rst_i), .code_i(channel_a_delay_code), .block_i(blk_a),
		.in_i(in_a), .out_o(a_out), .out_comp_o(a_comp)
	);
	delay_channel #(.DEPTH(DEPTH)) u_chan_b (
		.clk_i(clk_i), .rst_i(rst_i), .code_i(channel_b_delay_code), .block_i(blk_b),
		.in_i(in_b), .out_o(b_out), .out_comp_o(b_comp)
	);

	// Channel outputs registered at the top
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_a_output_o      <= 1'b0;
			channel_a_output_comp_o <= 1'b1;
			channel_b_output_o      <= 1'b0;
			channel_b_output_comp_o <= 1'b1;
		end else begin
			channel_a_output_o      <= a_out;
			channel_a_output_comp_o <= a_comp;
			channel_b_output_o      <= b_out;
			channel_b_output_comp_o <= b_comp;
		end
	end

	// Wishbone ack, one cycle, then dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	// Read data mux; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !ack_o && !we_i) begin
			case (adr_i)
				{1'b0, `REG_CTRL}:   dat_o <= {30'h0, ctrl};
				{1'b0, `REG_STATUS}: dat_o <= {24'h0, loads_seen, load_strobe, bit_count, 1'b0};
				{1'b0, `REG_CODE_A}: dat_o <= {22'h0, channel_a_delay_code};
				{1'b0, `REG_CODE_B}: dat_o <= {22'h0, channel_b_delay_code};
				`REG_CHAIN:          dat_o <= {12'h0, chain};
				default:             dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Codes only change while the strobe is high
	a_code_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!load_strobe |=> $stable(channel_a_delay_code))
		else $error("code changed with strobe low");
	// Chain shifts exactly on a clock rise
	a_chain_shift: assert property (@(posedge clk_i) disable iff (rst_i)
		sclk_rise |=> chain[0] == $past(sdi))
		else $error("chain did not take data bit");
	// Cascade output follows chain end
	a_cascade_out: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> serial_data_out_o == $past(chain[`WORD_WIDTH-1]))
		else $error("cascade out wrong");
	// Open latch passes chain to channel B code
	a_latch_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		load_strobe |=> channel_b_delay_code == $past(chain[`CODE_B_LSB +: `CODE_WIDTH]))
		else $error("latch not transparent");
	// Complement pair always opposite
	a_pair_opposite: assert property (@(posedge clk_i) disable iff (rst_i)
		channel_a_output_o != channel_a_output_comp_o)
		else $error("output pair not complementary");
	// Software block forces low within delay bound
	sequence s_blocked_a;
		ctrl[`CTRL_BLOCK_A] [*8];
	endsequence
	a_block_low: assert property (@(posedge clk_i) disable iff (rst_i)
		s_blocked_a and (channel_a_delay_code <= 10'h004) [*8] |-> !channel_a_output_o)
		else $error("blocked output not low");
	// Ack lasts a single cycle
	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held too long");
	// Load state leaves hold one cycle after the strobe falls, so it is out of hold once the strobe has been low three cycles
	a_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)
		!load_strobe [*3] |-> load_state != LOAD_HOLD)
		else $error("load state stuck");
	// Second pair always opposite
	a_pair_opp_b: assert property (@(posedge clk_i) disable iff (rst_i)
		channel_b_output_o != channel_b_output_comp_o)
		else $error("channel b pair not complementary");
	// Chain holds between serial clock rises
	a_chain_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!sclk_rise |=> $stable(chain))
		else $error("chain moved without clock rise");
	// Open latch passes channel A field too
	a_latch_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		load_strobe |=> channel_a_delay_code == $past(chain[`CODE_A_LSB +: `CODE_WIDTH]))
		else $error("latch not transparent for a");
	// Channel B code held while strobe low
	a_code_b_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!load_strobe |=> $stable(channel_b_delay_code))
		else $error("code b changed with strobe low");
	// Strobe rise opens the load sequence
	a_load_open: assert property (@(posedge clk_i) disable iff (rst_i)
		load_strobe_rise |=> load_state == LOAD_OPEN)
		else $error("strobe rise not tracked");
	// Bit count only grows until the next load
	a_count_grow: assert property (@(posedge clk_i) disable iff (rst_i)
		!load_strobe_rise |=> bit_count >= $past(bit_count))
		else $error("bit count dropped");
	// Ack only answers a request
	a_ack_request: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	// Pin block forces channel A low within delay bound
	sequence s_pin_block_a;
		blk_a_pin [*8];
	endsequence
	a_pin_block: assert property (@(posedge clk_i) disable iff (rst_i)
		s_pin_block_a and (channel_a_delay_code <= 10'h004) [*8] |-> !channel_a_output_o)
		else $error("pin blocked output not low");
endmodule : dual_delay_serial_control

// File: hw/pin_sync.sv
// Two-flop synchroniser for one pin from outside the clock domain
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pin in, synchronised level out
	input  wire logic pin_i,
	output logic      level_o
);
	logic meta;

	// First stage read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta    <= 1'b0;
			level_o <= 1'b0;
		end else begin
			meta    <= pin_i;
			level_o <= meta;
		end
	end
endmodule : pin_sync

// File: inc/delay_ctrl_map.svh
// Offsets, field positions, reset values and timing counts of the delay control block
`ifndef DELAY_CTRL_MAP_SVH
`define DELAY_CTRL_MAP_SVH

// Serial word layout: channel A code in the low ten bits, channel B above it
`define CODE_WIDTH        10
`define WORD_WIDTH        20
`define CODE_A_LSB        0
`define CODE_B_LSB        10

// Wishbone register byte offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_CODE_A        4'h8
`define REG_CODE_B        4'hc
`define REG_CHAIN         5'h10

// Control register fields
`define CTRL_BLOCK_A      0
`define CTRL_BLOCK_B      1

// Reset values
`define CTRL_RESET        2'h0
`define CODE_RESET        10'h000

// One delay step in clock cycles of the 25 MHz clock
`define CLK_PERIOD_NS     40
`define STEP_TIME_NS      40
`define STEP_CYCLES       ((`STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: inc/delay_ctrl_pkg.sv
// Types shared by the delay control block
package delay_ctrl_pkg;
	typedef logic [9:0]  delay_code_t;
	typedef logic [19:0] ctrl_word_t;
	typedef enum logic [1:0] {
		LOAD_IDLE,
		LOAD_OPEN,
		LOAD_HOLD
	} load_state_t;
endpackage : delay_ctrl_pkg

// File: verification/dual_delay_serial_control_tb_top.sv
// Self-checking bench of the dual delay serial control block
`timescale 1ns/1ps
`include "delay_ctrl_map.svh"
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end
module dual_delay_serial_control_tb_top;
	import delay_ctrl_pkg::*;
	localparam ctrl_word_t word_1 = {10'h203, 10'h005};
	localparam ctrl_word_t word_2 = {10'h001, 10'h001};
	logic        clk, rst, cyc, stb, we, sdi, sclk, load_strobe, sdo;
	logic        blk_a, blk_b, in_a, in_b, out_a, comp_a, out_b, comp_b, ack;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	int          error_cnt = 0;
	int          cmp_count = 0;
	// Device under test
	dual_delay_serial_control u_dual_delay_serial_control (.clk_i(clk), .rst_i(rst),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .serial_data_in_i(sdi), .serial_clock_i(sclk),
		.load_strobe_i(load_strobe), .serial_data_out_o(sdo), .channel_a_output_block_i(blk_a),
		.channel_b_output_block_i(blk_b), .channel_a_input_i(in_a), .channel_b_input_i(in_b),
		.channel_a_output_o(out_a), .channel_a_output_comp_o(comp_a),
		.channel_b_output_o(out_b), .channel_b_output_comp_o(comp_b));
	// Serial controller on the far side
	serial_host_model u_serial_host_model (.serial_data_in_o(sdi), .serial_clock_o(sclk),
		.load_strobe_o(load_strobe));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		@(posedge clk iff ack === 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	// Cycles from an input rise to the output rise
	task automatic meas(input bit b, output int n);
		n = 0;
		@(posedge clk);
		if (b) in_b <= 1'b1; else in_a <= 1'b1;
		do begin @(posedge clk); n++; end while ((b ? out_b : out_a) !== 1'b1);
		`CHK("comp while high", 1'b0, b ? comp_b : comp_a)
		if (b) in_b <= 1'b0; else in_a <= 1'b0;
		do @(posedge clk); while ((b ? out_b : out_a) !== 1'b0);
	endtask : meas
	// Values after reset and an unmapped read
	task automatic t_reset;
		logic [31:0] q;
		`CHK("out a reset", 1'b0, out_a)
		`CHK("comp a reset", 1'b1, comp_a)
		wb(1'b0, 5'(`REG_CODE_A), 32'h0, q);
		`CHK("code a reset", 10'h000, q[9:0])
		wb(1'b0, 5'h14, 32'h0, q);
		`CHK("unmapped read", 32'h0, q)
		$display("test reset done");
	endtask : t_reset
	// Shift, hold with strobe low, then open the latches
	task automatic t_program;
		logic [31:0] q;
		u_serial_host_model.shift_word(word_1);
		repeat (4) @(posedge clk);
		`CHK("cascade out", 1'b1, sdo)
		wb(1'b0, 5'(`REG_CODE_A), 32'h0, q);
		`CHK("code a before load", 10'h000, q[9:0])
		wb(1'b0, 5'(`REG_CHAIN), 32'h0, q);
		`CHK("chain", word_1, q[19:0])
		wb(1'b0, 5'(`REG_STATUS), 32'h0, q);
		`CHK("bits counted", 5'h14, q[5:1])
		u_serial_host_model.set_load(1'b1);
		wb(1'b0, 5'(`REG_CODE_A), 32'h0, q);
		`CHK("code a", word_1[9:0], q[9:0])
		wb(1'b0, 5'(`REG_CODE_B), 32'h0, q);
		`CHK("code b", word_1[19:10], q[9:0])
		u_serial_host_model.set_load(1'b0);
		$display("test program done");
	endtask : t_program
	// Delay difference between two codes per channel
	task automatic t_delay;
		int a_hi, b_hi, a_lo, b_lo;
		meas(1'b0, a_hi);
		meas(1'b1, b_hi);
		u_serial_host_model.shift_word(word_2);
		repeat (4) @(posedge clk);
		`CHK("cascade out", 1'b0, sdo)
		u_serial_host_model.set_load(1'b1);
		u_serial_host_model.set_load(1'b0);
		meas(1'b0, a_lo);
		meas(1'b1, b_lo);
		`CHK("delay step a", 4, a_hi - a_lo)
		`CHK("delay step b", 514, b_hi - b_lo)
		$display("test delay done");
	endtask : t_delay
	// Output block by pin and by control register
	task automatic t_block;
		logic [31:0] q;
		@(posedge clk);
		blk_a <= 1'b1;
		in_a <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("blocked out a", 1'b0, out_a)
		`CHK("blocked comp a", 1'b1, comp_a)
		blk_a <= 1'b0;
		in_a <= 1'b0;
		wb(1'b1, 5'(`REG_CTRL), 32'h3, q);
		in_a <= 1'b1;
		in_b <= 1'b1;
		repeat (20) @(posedge clk);
		`CHK("blocked out b", 1'b0, out_b)
		`CHK("blocked comp b", 1'b1, comp_b)
		`CHK("reg blocked out a", 1'b0, out_a)
		wb(1'b0, 5'(`REG_CTRL), 32'h0, q);
		`CHK("ctrl read", 2'h3, q[1:0])
		wb(1'b1, 5'(`REG_CTRL), 32'h0, q);
		repeat (20) @(posedge clk);
		`CHK("released out b", 1'b1, out_b)
		`CHK("released out a", 1'b1, out_a)
		in_a <= 1'b0;
		in_b <= 1'b0;
		$display("test block done");
	endtask : t_block
	// Verdict and end of run
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// Reset, then the scenarios
	initial begin
		{rst, cyc, stb, we, adr, sel, wdat} = {4'h8, 5'h00, 4'hf, 32'h0};
		{blk_a, blk_b, in_a, in_b} = 4'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_program();
		t_delay();
		t_block();
		stop_test();
	end
	// Watchdog against a hang
	initial begin
		#300us;
		error_cnt++;
		stop_test();
	end
endmodule : dual_delay_serial_control_tb_top

// File: verification/serial_host_model.sv
// Host model that shifts control words into the serial programming pins
`timescale 1ns/1ps
module serial_host_model (
	// Serial programming pins
	output logic serial_data_in_o,
	output logic serial_clock_o,
	output logic load_strobe_o
);
	localparam int HALF_NS = 160; // 320 ns link period, far below 40 MHz
	// Idle lines rest at their pull-down level, clock stands still
	initial begin
		serial_data_in_o = 1'b0;
		serial_clock_o   = 1'b0;
		load_strobe_o    = 1'b0;
	end
	// Whole word, top bit first, strobe kept low meanwhile
	task automatic shift_word(input logic [19:0] word);
		#7;
		for (int i = 19; i >= 0; i--) begin
			serial_data_in_o = word[i];
			#HALF_NS;
			serial_clock_o = 1'b1;
			#HALF_NS;
			serial_clock_o = 1'b0;
		end
		#HALF_NS;
		serial_data_in_o = 1'b0; // Released line falls to pull-down
	endtask : shift_word
	// Strobe level; no clock edge while it is high
	task automatic set_load(input logic level);
		#7;
		load_strobe_o = level;
		#400;
	endtask : set_load
endmodule : serial_host_model
